/* design/rsi_pkg.sv */
// rsi_pkg: constants shared by the reset state initializer
// assumes 8-bit register images and a 40 MHz system clock
package rsi_pkg;
   localparam int DATA_W = 8;
   localparam int PC_W = 13;
   localparam int SP_W = 3;
   localparam int CLK_MHZ = 40;
   // reset images of the reloaded registers
   localparam logic [7:0] PORT_DIR_RST = 8'hFF;
   localparam logic [7:0] PORT_DATA_RST = 8'hFF;
   localparam logic [7:0] PULLUP_RST = 8'h00;
   localparam logic [7:0] WDT_CTRL_RST = 8'h53;
   localparam logic [7:0] TMR_CTRL_RST = 8'h00;
   localparam logic [7:0] INT_CTRL_RST = 8'h00;
   localparam logic [PC_W-1:0] PC_RST = 13'h0000;
   localparam logic [SP_W-1:0] SP_RST = 3'h0;
   // status register field positions
   localparam int STAT_PDF_BIT = 4;
   localparam int STAT_TO_BIT = 5;
   // cycles the reset pulse to the core is held
   localparam int HOLD_CYC = 4;
   localparam logic [2:0] HOLD_CYC_W = 3'h4;
   typedef enum logic [2:0] {
      RSI_SRC_NONE = 3'b000,
      RSI_SRC_POR = 3'b001,
      RSI_SRC_PIN = 3'b010,
      RSI_SRC_WDT_RUN = 3'b011,
      RSI_SRC_WDT_HALT = 3'b100
   } rsi_src_e;
endpackage

/* design/rsi_sync.sv */
// rsi_sync: two-flop synchroniser for one asynchronous level
// assumes clk is the system clock and rst_n is already synchronised
`timescale 1ns/1ps
module rsi_sync (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic async_in,
   output logic sync_out
);
   logic meta_q;
   logic meta_d;
   logic sync_q;
   logic sync_d;
   always_comb begin
      meta_d = async_in;
      sync_d = meta_q;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end
   assign sync_out = sync_q;
endmodule

/* design/rsi_reset_state_initializer.sv */
// rsi_reset_state_initializer: applies reset-state policy per reset source
// assumes reset sources are asynchronous levels, active high, one at a time
`timescale 1ns/1ps
module rsi_reset_state_initializer (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic por_req,
   input wire logic pin_reset,
   input wire logic low_voltage_reset,
   input wire logic watchdog_timeout,
   input wire logic cpu_halted,
   output logic core_reset,
   output logic timeout_flag,
   output logic power_down_flag,
   output logic reload_periph,
   output logic [rsi_pkg::PC_W-1:0] program_counter,
   output logic [rsi_pkg::SP_W-1:0] stack_pointer,
   output logic int_enable_clr,
   output logic [7:0] int_ctrl,
   output logic watchdog_timer_clr,
   output logic [7:0] watchdog_control_reg,
   output logic [7:0] timer_ctrl,
   output logic [7:0] port_dir,
   output logic [7:0] port_data,
   output logic [7:0] port_pullup,
   output logic keep_core_regs,
   output logic [2:0] last_source
);
   logic rst_meta_q;
   logic rst_n;
   logic por_s;
   logic pin_s;
   logic lvr_s;
   logic wdt_s;
   logic halt_s;
   logic hw_rst;
   logic hw_prev_q;
   logic hw_prev_d;
   logic [2:0] hold_q;
   logic [2:0] hold_d;
   logic to_q;
   logic to_d;
   logic pdf_q;
   logic pdf_d;
   logic reload_q;
   logic reload_d;
   logic [rsi_pkg::PC_W-1:0] pc_q;
   logic [rsi_pkg::PC_W-1:0] pc_d;
   logic [rsi_pkg::SP_W-1:0] sp_q;
   logic [rsi_pkg::SP_W-1:0] sp_d;
   logic intclr_q;
   logic intclr_d;
   logic wdtclr_q;
   logic wdtclr_d;
   logic keep_q;
   logic keep_d;
   logic [7:0] intc_q;
   logic [7:0] intc_d;
   logic [7:0] watchdog_control_reg_q;
   logic [7:0] watchdog_control_reg_d;
   logic [7:0] tmr_q;
   logic [7:0] tmr_d;
   logic [7:0] dir_q;
   logic [7:0] dir_d;
   logic [7:0] dat_q;
   logic [7:0] dat_d;
   logic [7:0] pu_q;
   logic [7:0] pu_d;
   rsi_pkg::rsi_src_e src_q;
   rsi_pkg::rsi_src_e src_d;
   rsi_pkg::rsi_src_e src_now;

   // reset release through two flops
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n <= rst_meta_q;
      end
   end

   rsi_sync u_sync_por (.clk(ref_clk), .rst_n(rst_n), .async_in(por_req),
      .sync_out(por_s));
   rsi_sync u_sync_pin (.clk(ref_clk), .rst_n(rst_n), .async_in(pin_reset),
      .sync_out(pin_s));
   rsi_sync u_sync_lvr (.clk(ref_clk), .rst_n(rst_n),
      .async_in(low_voltage_reset), .sync_out(lvr_s));
   rsi_sync u_sync_wdt (.clk(ref_clk), .rst_n(rst_n),
      .async_in(watchdog_timeout), .sync_out(wdt_s));
   rsi_sync u_sync_halt (.clk(ref_clk), .rst_n(rst_n), .async_in(cpu_halted),
      .sync_out(halt_s));

   // source priority: power-on, pin/low-voltage, watchdog
   always_comb begin
      if (por_s) begin
         src_now = rsi_pkg::RSI_SRC_POR;
      end else if (pin_s || lvr_s) begin
         src_now = rsi_pkg::RSI_SRC_PIN;
      end else if (wdt_s && halt_s) begin
         src_now = rsi_pkg::RSI_SRC_WDT_HALT;
      end else if (wdt_s) begin
         src_now = rsi_pkg::RSI_SRC_WDT_RUN;
      end else begin
         src_now = rsi_pkg::RSI_SRC_NONE;
      end
   end
   assign hw_rst = (src_now != rsi_pkg::RSI_SRC_NONE);

   always_comb begin
      hw_prev_d = hw_rst;
      hold_d = (hold_q != 3'h0) ? hold_q - 3'h1 : 3'h0;
      to_d = to_q;
      pdf_d = pdf_q;
      reload_d = 1'b0;
      pc_d = pc_q;
      sp_d = sp_q;
      intclr_d = 1'b0;
      wdtclr_d = 1'b0;
      keep_d = keep_q;
      intc_d = intc_q;
      watchdog_control_reg_d = watchdog_control_reg_q;
      tmr_d = tmr_q;
      dir_d = dir_q;
      dat_d = dat_q;
      pu_d = pu_q;
      src_d = src_q;
      if (hw_rst && !hw_prev_q) begin
         src_d = src_now;
         hold_d = rsi_pkg::HOLD_CYC_W;
         pc_d = rsi_pkg::PC_RST;
         sp_d = rsi_pkg::SP_RST;
         wdtclr_d = 1'b1;
         case (src_now)
            rsi_pkg::RSI_SRC_POR: begin
               to_d = 1'b0;
               pdf_d = 1'b0;
               keep_d = 1'b0;
            end
            rsi_pkg::RSI_SRC_PIN: begin
               keep_d = 1'b1;
            end
            rsi_pkg::RSI_SRC_WDT_RUN: begin
               to_d = 1'b1;
               keep_d = 1'b1;
            end
            rsi_pkg::RSI_SRC_WDT_HALT: begin
               to_d = 1'b1;
               pdf_d = 1'b1;
               keep_d = 1'b1;
            end
            default: begin
               keep_d = keep_q;
            end
         endcase
         if (src_now != rsi_pkg::RSI_SRC_WDT_HALT) begin
            reload_d = 1'b1;
            intclr_d = 1'b1;
            intc_d = rsi_pkg::INT_CTRL_RST;
            watchdog_control_reg_d = rsi_pkg::WDT_CTRL_RST;
            tmr_d = rsi_pkg::TMR_CTRL_RST;
            dir_d = rsi_pkg::PORT_DIR_RST;
            dat_d = rsi_pkg::PORT_DATA_RST;
            pu_d = rsi_pkg::PULLUP_RST;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         hw_prev_q <= 1'b0;
         hold_q <= rsi_pkg::HOLD_CYC_W;
         to_q <= 1'b0;
         pdf_q <= 1'b0;
         reload_q <= 1'b1;
         pc_q <= rsi_pkg::PC_RST;
         sp_q <= rsi_pkg::SP_RST;
         intclr_q <= 1'b1;
         wdtclr_q <= 1'b1;
         keep_q <= 1'b0;
         intc_q <= rsi_pkg::INT_CTRL_RST;
         watchdog_control_reg_q <= rsi_pkg::WDT_CTRL_RST;
         tmr_q <= rsi_pkg::TMR_CTRL_RST;
         dir_q <= rsi_pkg::PORT_DIR_RST;
         dat_q <= rsi_pkg::PORT_DATA_RST;
         pu_q <= rsi_pkg::PULLUP_RST;
         src_q <= rsi_pkg::RSI_SRC_POR;
      end else begin
         hw_prev_q <= hw_prev_d;
         hold_q <= hold_d;
         to_q <= to_d;
         pdf_q <= pdf_d;
         reload_q <= reload_d;
         pc_q <= pc_d;
         sp_q <= sp_d;
         intclr_q <= intclr_d;
         wdtclr_q <= wdtclr_d;
         keep_q <= keep_d;
         intc_q <= intc_d;
         watchdog_control_reg_q <= watchdog_control_reg_d;
         tmr_q <= tmr_d;
         dir_q <= dir_d;
         dat_q <= dat_d;
         pu_q <= pu_d;
         src_q <= src_d;
      end
   end

   assign core_reset = (hold_q != 3'h0) || hw_rst;
   assign timeout_flag = to_q;
   assign power_down_flag = pdf_q;
   assign reload_periph = reload_q;
   assign program_counter = pc_q;
   assign stack_pointer = sp_q;
   assign int_enable_clr = intclr_q;
   assign int_ctrl = intc_q;
   assign watchdog_timer_clr = wdtclr_q;
   assign watchdog_control_reg = watchdog_control_reg_q;
   assign timer_ctrl = tmr_q;
   assign port_dir = dir_q;
   assign port_data = dat_q;
   assign port_pullup = pu_q;
   assign keep_core_regs = keep_q;
   assign last_source = src_q;
endmodule

/* bench/rsi_reset_state_initializer_chk.sv */
// checker: reset-state policy relations on the initializer ports
// assumes bind onto rsi_reset_state_initializer, one clock ref_clk
`timescale 1ns/1ps
module rsi_reset_chk (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic watchdog_timeout,
   input wire logic cpu_halted,
   input wire logic core_reset,
   input wire logic timeout_flag,
   input wire logic power_down_flag,
   input wire logic reload_periph,
   input wire logic [rsi_pkg::PC_W-1:0] program_counter,
   input wire logic [rsi_pkg::SP_W-1:0] stack_pointer,
   input wire logic int_enable_clr,
   input wire logic [7:0] int_ctrl,
   input wire logic watchdog_timer_clr,
   input wire logic [7:0] watchdog_control_reg,
   input wire logic [7:0] timer_ctrl,
   input wire logic [7:0] port_dir,
   input wire logic [7:0] port_pullup,
   input wire logic keep_core_regs,
   input wire logic [2:0] last_source
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   AST_WDT_FLAG: assert property (last_source == 3'h3 |-> timeout_flag)
      else $error("time-out flag low after running watchdog reset");
   AST_HALT_FLAGS: assert property (last_source == 3'h4 |->
      timeout_flag && power_down_flag) else $error("halted flags wrong");
   AST_POR_FLAGS: assert property (last_source == 3'h1 |->
      !timeout_flag && !power_down_flag && !keep_core_regs)
      else $error("power-on state wrong");
   AST_PIN_KEEP: assert property (reload_periph && last_source == 3'h2
      |-> $stable(timeout_flag) && $stable(power_down_flag))
      else $error("pin reset changed a flag");
   AST_PC_SP: assert property (watchdog_timer_clr |->
      program_counter == '0 && stack_pointer == '0)
      else $error("pc or sp not cleared");
   AST_INT_OFF: assert property (reload_periph |-> int_enable_clr &&
      int_ctrl == rsi_pkg::INT_CTRL_RST) else $error("interrupts not off");
   AST_WDT_CLR: assert property (reload_periph |-> watchdog_timer_clr)
      else $error("watchdog not cleared with reload");
   AST_IMAGES: assert property (reload_periph |->
      watchdog_control_reg == rsi_pkg::WDT_CTRL_RST &&
      timer_ctrl == rsi_pkg::TMR_CTRL_RST && port_dir == rsi_pkg::PORT_DIR_RST
      && port_pullup == rsi_pkg::PULLUP_RST) else $error("images wrong");
   AST_HALT_LAT: assert property ($rose(watchdog_timeout) &&
      cpu_halted && !core_reset |-> ##[1:4] last_source == 3'h4)
      else $error("halted watchdog reset late");
   COV_RUN: cover property (last_source == 3'h3 && reload_periph);
   COV_HALT: cover property (last_source == 3'h4 && watchdog_timer_clr);
   COV_PIN: cover property (last_source == 3'h2 && reload_periph);
endmodule
bind rsi_reset_state_initializer rsi_reset_chk i_rsi_reset_chk (
   .ref_clk(ref_clk), .resetn(resetn), .watchdog_timeout(watchdog_timeout),
   .cpu_halted(cpu_halted), .core_reset(core_reset),
   .timeout_flag(timeout_flag), .power_down_flag(power_down_flag),
   .reload_periph(reload_periph), .program_counter(program_counter),
   .stack_pointer(stack_pointer), .int_enable_clr(int_enable_clr),
   .int_ctrl(int_ctrl), .watchdog_timer_clr(watchdog_timer_clr),
   .watchdog_control_reg(watchdog_control_reg), .timer_ctrl(timer_ctrl),
   .port_dir(port_dir), .port_pullup(port_pullup),
   .keep_core_regs(keep_core_regs), .last_source(last_source));

/* bench/tb_top.sv */
// testbench: drives each reset source and checks flags and images
// assumes the checker file is compiled alongside for its bind
`timescale 1ns/1ps
module tb_top;
   logic ref_clk = 0, resetn = 0, por_req = 0, pin_reset = 0;
   logic low_voltage_reset = 0, watchdog_timeout = 0, cpu_halted = 0;
   logic core_reset, timeout_flag, power_down_flag, reload_periph;
   logic int_enable_clr, watchdog_timer_clr, keep_core_regs;
   logic [rsi_pkg::PC_W-1:0] program_counter;
   logic [rsi_pkg::SP_W-1:0] stack_pointer;
   logic [7:0] int_ctrl, watchdog_control_reg, timer_ctrl;
   logic [7:0] port_dir, port_data, port_pullup;
   logic [2:0] last_source;
   int n_errors = 0, tests_run = 0, n_rl, n_wc, n_cr;
   initial forever #12.5 ref_clk = ~ref_clk;
   rsi_reset_state_initializer i_rsi_reset_state_initializer (
      .ref_clk(ref_clk), .resetn(resetn), .por_req(por_req),
      .pin_reset(pin_reset), .low_voltage_reset(low_voltage_reset),
      .watchdog_timeout(watchdog_timeout), .cpu_halted(cpu_halted),
      .core_reset(core_reset), .timeout_flag(timeout_flag),
      .power_down_flag(power_down_flag), .reload_periph(reload_periph),
      .program_counter(program_counter), .stack_pointer(stack_pointer),
      .int_enable_clr(int_enable_clr), .int_ctrl(int_ctrl),
      .watchdog_timer_clr(watchdog_timer_clr),
      .watchdog_control_reg(watchdog_control_reg), .timer_ctrl(timer_ctrl),
      .port_dir(port_dir), .port_data(port_data), .port_pullup(port_pullup),
      .keep_core_regs(keep_core_regs), .last_source(last_source));
   task chk(input string nm, input logic [12:0] s, input logic [12:0] e);
      tests_run++;
      if (s !== e) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   // one source held 5 cycles, pulses counted until all settles
   task fire(input int k, input logic h);
      n_rl = 0;
      n_wc = 0;
      n_cr = 0;
      @(posedge ref_clk);
      cpu_halted <= h;
      @(posedge ref_clk);
      case (k)
         0: por_req <= 1'b1;
         1: pin_reset <= 1'b1;
         2: low_voltage_reset <= 1'b1;
         default: watchdog_timeout <= 1'b1;
      endcase
      for (int i = 0; i < 14; i++) begin
         @(posedge ref_clk);
         if (i == 4) begin
            por_req <= 1'b0;
            pin_reset <= 1'b0;
            low_voltage_reset <= 1'b0;
            watchdog_timeout <= 1'b0;
         end
         #1;
         n_rl += reload_periph;
         n_wc += watchdog_timer_clr;
         n_cr += core_reset;
      end
   endtask
   task flags(input logic to, input logic pd, input logic [2:0] ls);
      chk("timeout_flag", timeout_flag, to);
      chk("power_down_flag", power_down_flag, pd);
      chk("last_source", last_source, ls);
      chk("watchdog clears", 13'(n_wc), 13'h1);
      chk("core_reset held", 13'(n_cr >= rsi_pkg::HOLD_CYC), 13'h1);
      chk("core_reset settled", core_reset, 13'h0);
      chk("program_counter", program_counter, 0);
      chk("stack_pointer", stack_pointer, 0);
   endtask
   task t_power_on;
      chk("timeout_flag", timeout_flag, 0);
      chk("power_down_flag", power_down_flag, 0);
      chk("keep_core_regs", keep_core_regs, 0);
      chk("int_ctrl", int_ctrl, 0);
      chk("timer_ctrl", timer_ctrl, 0);
      chk("port_dir", port_dir, 8'hff);
      chk("port_data", port_data, 8'hff);
      chk("port_pullup", port_pullup, 0);
      chk("watchdog_control_reg", watchdog_control_reg, 8'h53);
      $display("test power_on done");
   endtask
   task t_wdt_run;
      fire(3, 1'b0);
      flags(1'b1, 1'b0, 3'h3);
      chk("reloads", 13'(n_rl), 13'h1);
      chk("keep_core_regs", keep_core_regs, 1);
      $display("test wdt_run done");
   endtask
   task t_pin_after_wdt;
      fire(1, 1'b0);
      flags(1'b1, 1'b0, 3'h2);
      chk("reloads", 13'(n_rl), 13'h1);
      $display("test pin done");
   endtask
   task t_wdt_halt;
      fire(3, 1'b1);
      flags(1'b1, 1'b1, 3'h4);
      chk("reloads", 13'(n_rl), 13'h0);
      $display("test wdt_halt done");
   endtask
   task t_lvr_keep;
      fire(2, 1'b0);
      flags(1'b1, 1'b1, 3'h2);
      $display("test lvr done");
   endtask
   task t_por_then_pin;
      fire(0, 1'b0);
      flags(1'b0, 1'b0, 3'h1);
      chk("keep_core_regs", keep_core_regs, 0);
      fire(1, 1'b0);
      flags(1'b0, 1'b0, 3'h2);
      $display("test por_then_pin done");
   endtask
   task results;
      $display("compares %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (8) @(posedge ref_clk);
      #1;
      t_power_on;
      t_wdt_run;
      t_pin_after_wdt;
      t_wdt_halt;
      t_lvr_keep;
      t_por_then_pin;
      results;
   end
   initial begin
      repeat (2000) @(posedge ref_clk);
      n_errors++;
      results;
   end
endmodule
